// >>> common/tat_pkg.sv
// Purpose: shared constants and types of the table access / test / xor unit
// Assumes: one core clock edge per quarter-phase, four per instruction cycle
// Notes: opcode fields are matched against the registered instruction word
package tat_pkg;

    // quarter-phases of one instruction cycle
    localparam logic [1:0] TAT_Q1 = 2'h0;
    localparam logic [1:0] TAT_Q2 = 2'h1;
    localparam logic [1:0] TAT_Q3 = 2'h2;
    localparam logic [1:0] TAT_Q4 = 2'h3;

    // widths
    localparam int TAT_PTR_W = 21;
    localparam int TAT_HOLD_N = 8;
    localparam int TAT_HOLD_IDX_W = 3;
    localparam int TAT_BANK_W = 4;

    // opcode fields: upper byte, then fields of the lower byte
    localparam logic [7:0] TAT_TBL_OPC = 8'h00;
    localparam logic [5:0] TAT_TRD_SEL = 6'h02;
    localparam logic [5:0] TAT_TWR_SEL = 6'h03;
    localparam logic [6:0] TAT_TST_OPC = 7'h33;
    localparam logic [7:0] TAT_XOR_OPC = 8'h0A;

    // quick-access bank: low half maps to bank 0, high half to the top bank
    localparam logic [7:0] TAT_ACC_SPLIT = 8'h80;
    localparam logic [3:0] TAT_BANK_LOW = 4'h0;
    localparam logic [3:0] TAT_BANK_HIGH = 4'hF;

    // reset values
    localparam logic [20:0] TAT_PTR_RST = 21'h000000;
    localparam logic [7:0] TAT_LATCH_RST = 8'h00;
    localparam logic [7:0] TAT_HOLD_RST = 8'hFF;
    localparam logic [7:0] TAT_ACC_RST = 8'h00;

    // pointer handling selected by the two low argument-byte bits
    typedef enum logic [1:0] {
        TAT_MODE_KEEP,
        TAT_MODE_POST_INC,
        TAT_MODE_POST_DEC,
        TAT_MODE_PRE_INC
    } tat_mode_t;

    // execution sequencer
    typedef enum logic [2:0] {
        TAT_ST_IDLE,
        TAT_ST_EXEC,
        TAT_ST_TBL2,
        TAT_ST_SKIP1,
        TAT_ST_SKIP2
    } tat_state_t;

    // one program word: opcode byte and argument byte
    typedef struct packed {
        logic [7:0] opc;
        logic [7:0] arg;
    } tat_instr_t;

    // arithmetic flags this unit may change
    typedef struct packed {
        logic neg;
        logic zero;
    } tat_flags_t;

endpackage

// >>> verilog/tat_decode_exec.sv
// Purpose: decode and execute table read/write, test-skip-zero, xor literal
// Assumes: all inputs synchronous to core_clk; flash and file data valid
//          from the quarter-phase after their request until Q4
// Notes: unrecognised opcodes pass as one-cycle no-operations
//
// Overview of operation
// - table read copies the flash byte at the pointer into the latch
// - the table pointer is 21 bits and addresses single bytes
// - pointer bit zero picks low byte (0) or high byte (1) of a word
// - mode 0 keeps, 1 post-increments, 2 post-decrements, 3 pre-increments
// - table read takes two cycles; latch written in Q4 of the second
// - table write stores latch into holding register picked by pointer[2:0]
// - eight holding registers stage bytes for later flash programming
// - table write decodes as twelve zeros, then 11, then the mode field
// - table ops and test-skip leave the arithmetic flags untouched
// - test-skip decodes as 0110011, access bit, then file address
// - a zero file register discards the prefetched instruction for a nop
// - test-skip takes one cycle, two when skipping, three over two words
// - access bit 0 forces the quick-access bank; 1 uses bank select
// - xor literal xors accumulator with immediate, updating only N and Z
`timescale 1ns/100ps

module tat_decode_exec
    import tat_pkg::*;
#(
    parameter int PTR_W = TAT_PTR_W,
    parameter int HOLD_N = TAT_HOLD_N
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire tat_instr_t instr,
    output logic instr_ready,
    input wire logic prefetch_two_word,
    output logic prefetch_discard,
    output logic [1:0] quarter_phase,
    output logic pm_rd,
    output logic [PTR_W-1:0] pm_addr,
    input wire logic [15:0] pm_rdata,
    input wire logic [TAT_BANK_W-1:0] bank_select_register,
    output logic fr_rd,
    output logic [TAT_BANK_W+7:0] fr_addr,
    input wire logic [7:0] fr_rdata,
    input wire logic ptr_load,
    input wire logic [PTR_W-1:0] ptr_load_value,
    input wire logic latch_load,
    input wire logic [7:0] latch_load_value,
    output logic [PTR_W-1:0] table_pointer,
    output logic [7:0] table_latch,
    output logic [HOLD_N-1:0][7:0] hold_regs,
    output logic [7:0] accumulator,
    output tat_flags_t flags,
    output logic busy
);

    tat_state_t state;
    tat_state_t next_state;
    tat_instr_t cur;
    logic [1:0] q;
    logic is_trd;
    logic is_twr;
    logic is_tbl;
    logic is_tst;
    logic is_xor;
    tat_mode_t mode;
    logic tst_zero;
    logic [7:0] wr_data;
    logic [PTR_W-1:0] next_ptr;
    logic [7:0] next_acc;
    logic q4;
    logic take;
    logic hold_we;
    logic [TAT_HOLD_IDX_W-1:0] hold_idx;

    // quarter-phase counter; each core edge is one quarter of a cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= TAT_Q1;
        end else begin
            q <= q + 2'h1;
        end
    end

    assign quarter_phase = q;
    // a word offered outside idle Q1 waits; nothing is queued
    assign q4 = (q == TAT_Q4);
    assign instr_ready = (state == TAT_ST_IDLE) && (q == TAT_Q1);
    assign take = instr_ready && instr_valid;
    assign busy = (state != TAT_ST_IDLE);

    // decode from the word captured at Q1
    assign is_tbl = (cur.opc == TAT_TBL_OPC);
    assign is_trd = is_tbl && (cur.arg[7:2] == TAT_TRD_SEL);
    assign is_twr = is_tbl && (cur.arg[7:2] == TAT_TWR_SEL);
    assign is_tst = (cur.opc[7:1] == TAT_TST_OPC);
    assign is_xor = (cur.opc == TAT_XOR_OPC);
    // both table ops share the mode encoding
    assign mode = tat_mode_t'(cur.arg[1:0]);

    // instruction word latched at decode time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur <= '0;
        end else if (take) begin
            cur <= instr;
        end
    end

    // file address: a=0 forces quick-access bank, a=1 uses bank select
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fr_addr <= '0;
        end else if (take) begin
            if (instr.opc[0]) begin
                fr_addr <= {bank_select_register, instr.arg};
            end else if (instr.arg < TAT_ACC_SPLIT) begin
                fr_addr <= {TAT_BANK_LOW, instr.arg};
            end else begin
                fr_addr <= {TAT_BANK_HIGH, instr.arg};
            end
        end
    end

    // file register is read in Q2 of the test-skip cycle
    assign fr_rd = (state == TAT_ST_EXEC) && is_tst && (q == TAT_Q2);

    // zero test in Q3; result acted on at Q4
    // sampled for every op, read only by test-skip
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tst_zero <= 1'b0;
        end else if ((state == TAT_ST_EXEC) && (q == TAT_Q3)) begin
            tst_zero <= (fr_rdata == 8'h00);
        end
    end

    // discard pulse tells the fetch stage to drop the prefetched word
    assign prefetch_discard = (state == TAT_ST_EXEC) && is_tst && q4
        && tst_zero;

    // sequencer: every instruction ends at a Q4 edge
    always_comb begin
        next_state = state;
        case (state)
            TAT_ST_IDLE: begin
                if (take) begin
                    next_state = TAT_ST_EXEC;
                end
            end
            TAT_ST_EXEC: begin
                if (q4) begin
                    if (is_trd || is_twr) begin
                        next_state = TAT_ST_TBL2;
                    end else if (is_tst && tst_zero) begin
                        next_state = TAT_ST_SKIP1;
                    end else begin
                        // xor and unknown opcodes end after one cycle
                        next_state = TAT_ST_IDLE;
                    end
                end
            end
            TAT_ST_TBL2: begin
                // both table ops leave after their second Q4
                if (q4) begin
                    next_state = TAT_ST_IDLE;
                end
            end
            TAT_ST_SKIP1: begin
                // a two-word victim costs one more nop cycle
                if (q4) begin
                    if (prefetch_two_word) begin
                        next_state = TAT_ST_SKIP2;
                    end else begin
                        next_state = TAT_ST_IDLE;
                    end
                end
            end
            TAT_ST_SKIP2: begin
                // second word of the victim is also dropped
                if (q4) begin
                    next_state = TAT_ST_IDLE;
                end
            end
            default: begin
                // unused encodings recover to idle
                next_state = TAT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= TAT_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // pointer: pre-increment ends cycle one, post updates end cycle two;
    // instruction updates win over a software load in the same edge
    always_comb begin
        next_ptr = table_pointer;
        if ((state == TAT_ST_EXEC) && q4 && (is_trd || is_twr)
            && (mode == TAT_MODE_PRE_INC)) begin
            next_ptr = table_pointer + PTR_W'(1);
        end else if ((state == TAT_ST_TBL2) && q4
            && (mode == TAT_MODE_POST_INC)) begin
            next_ptr = table_pointer + PTR_W'(1);
        end else if ((state == TAT_ST_TBL2) && q4
            && (mode == TAT_MODE_POST_DEC)) begin
            next_ptr = table_pointer - PTR_W'(1);
        end else if (ptr_load) begin
            next_ptr = ptr_load_value;
        end
    end

    // byte-granular pointer wraps across the whole address space
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            table_pointer <= PTR_W'(TAT_PTR_RST);
        end else begin
            table_pointer <= next_ptr;
        end
    end

    // flash address frozen at Q1 of cycle two, so a late load cannot tear it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pm_addr <= '0;
        end else if ((state == TAT_ST_TBL2) && (q == TAT_Q1) && is_trd) begin
            pm_addr <= table_pointer;
        end
    end

    // flash read strobe in Q2 of the second cycle
    // one quarter only, so the flash sees a single request
    assign pm_rd = (state == TAT_ST_TBL2) && is_trd && (q == TAT_Q2);

    // latch: byte chosen by pointer bit zero, written at Q4 of cycle two
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            table_latch <= TAT_LATCH_RST;
        end else if ((state == TAT_ST_TBL2) && q4 && is_trd) begin
            if (pm_addr[0]) begin
                table_latch <= pm_rdata[15:8];
            end else begin
                table_latch <= pm_rdata[7:0];
            end
        end else if (latch_load) begin
            table_latch <= latch_load_value;
        end
    end

    // table write samples the latch at the end of its first cycle
    // a later latch load cannot change the byte in flight
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_data <= TAT_LATCH_RST;
        end else if ((state == TAT_ST_EXEC) && q4 && is_twr) begin
            wr_data <= table_latch;
        end
    end

    // index uses the pointer after any pre-increment
    assign hold_we = (state == TAT_ST_TBL2) && q4 && is_twr;
    assign hold_idx = table_pointer[TAT_HOLD_IDX_W-1:0];

    // staging buffer drained later by the flash programming sequence
    // index wraps every eight bytes of pointer
    for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                hold_regs[i] <= TAT_HOLD_RST;
            end else if (hold_we && (hold_idx == TAT_HOLD_IDX_W'(i))) begin
                hold_regs[i] <= wr_data;
            end
        end
    end

    // xor result written to the accumulator at Q4
    assign next_acc = accumulator ^ cur.arg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            accumulator <= TAT_ACC_RST;
        end else if ((state == TAT_ST_EXEC) && q4 && is_xor) begin
            accumulator <= next_acc;
        end
    end

    // only xor touches flags; table and test ops never reach here
    // kept out of the table paths so no status side effect can leak
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flags <= '0;
        end else if ((state == TAT_ST_EXEC) && q4 && is_xor) begin
            flags.neg <= next_acc[7];
            flags.zero <= (next_acc == 8'h00);
        end
    end

endmodule

// >>> verif/tat_flash_model.sv
// Purpose: program flash model for table reads
// Assumes: byte value is a fixed function of its address
// Notes: outside a read the data lines show inverted data
`timescale 1ns/100ps
module tat_flash_model
    import tat_pkg::*;
(
    input wire logic core_clk,
    input wire logic pm_rd,
    input wire logic [TAT_PTR_W-1:0] pm_addr,
    input wire logic [1:0] quarter_phase,
    output logic [15:0] pm_rdata
);
    logic hold = 1'b0;
    // each byte differs from its word partner in bit 0, so a wrong pick shows
    function automatic logic [7:0] fbyte(input logic [20:0] a);
        return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]} ^ 8'h5A;
    endfunction
    // data valid from the request up to the Q4 edge
    always_ff @(posedge core_clk) begin
        hold <= pm_rd || (hold && quarter_phase != TAT_Q4);
    end
    // even byte low, odd byte high
    assign pm_rdata = {fbyte({pm_addr[20:1], 1'b1}),
        fbyte({pm_addr[20:1], 1'b0})} ^ {16{!(pm_rd || hold)}};
endmodule

// >>> verif/tat_decode_exec_sva.sv
// Purpose: port checks on the decode and execute unit
// Assumes: bound to tat_decode_exec
// Notes: operands are captured at the take edge
`timescale 1ns/100ps
module tat_decode_exec_sva
    import tat_pkg::*;
#(
    parameter int PTR_W = TAT_PTR_W,
    parameter int HOLD_N = TAT_HOLD_N
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire tat_instr_t instr,
    input wire logic instr_ready,
    input wire logic [1:0] quarter_phase,
    input wire logic prefetch_two_word,
    input wire logic prefetch_discard,
    input wire logic pm_rd,
    input wire logic [PTR_W-1:0] pm_addr,
    input wire logic [15:0] pm_rdata,
    input wire logic [TAT_BANK_W-1:0] bank_select_register,
    input wire logic fr_rd,
    input wire logic [TAT_BANK_W+7:0] fr_addr,
    input wire logic [7:0] fr_rdata,
    input wire logic [PTR_W-1:0] table_pointer,
    input wire logic [7:0] table_latch,
    input wire logic [HOLD_N-1:0][7:0] hold_regs,
    input wire logic [7:0] accumulator,
    input wire tat_flags_t flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // decode of the word at the take edge
    wire take = instr_valid && instr_ready;
    wire tbl = take && instr.opc == TAT_TBL_OPC;
    wire trd = tbl && instr.arg[7:2] == TAT_TRD_SEL;
    wire twr = tbl && instr.arg[7:2] == TAT_TWR_SEL;
    wire tst = take && instr.opc[7:1] == TAT_TST_OPC;
    wire [1:0] md = instr.arg[1:0];
    wire [PTR_W-1:0] pa = table_pointer + PTR_W'(md == 2'h3);
    wire [PTR_W-1:0] pz = pa + PTR_W'(md == 2'h1) - PTR_W'(md == 2'h2);
    wire [3:0] bk = instr.opc[0] ? bank_select_register :
        (instr.arg >= TAT_ACC_SPLIT ? TAT_BANK_HIGH : TAT_BANK_LOW);
    wire [11:0] fa = {bk, instr.arg};
    wire [2:0] pi = pa[2:0];
    wire [7:0] pb = pm_addr[0] ? pm_rdata[15:8] : pm_rdata[7:0];
    wire [7:0] xr = accumulator ^ instr.arg;
    wire [1:0] xf = {xr[7], xr == 8'h00};
    wire xop = take && instr.opc == TAT_XOR_OPC;
    // operands held by $past, which more tools take than sequence locals
    latch_fill_a: assert property (pm_rd |->
        ##3 table_latch == $past(pb, 3)) else $error("latch byte wrong");
    ptr_mode_a: assert property (trd || twr |->
        ##8 table_pointer == $past(pz, 8))
        else $error("pointer update wrong");
    hold_write_a: assert property (twr |->
        ##8 hold_regs[$past(pi, 8)] == $past(table_latch, 8))
        else $error("holding write wrong");
    xor_result_a: assert property (xop |->
        ##4 accumulator == $past(xr, 4) && flags == $past(xf, 4))
        else $error("xor result wrong");
    phase_step_a: assert property ($past(rst_n) |->
        quarter_phase == $past(quarter_phase) + 2'h1)
        else $error("quarter phase skipped");
    table_len_a: assert property (trd || twr |->
        ##1 !instr_ready [*7] ##1 instr_ready) else $error("table length");
    bank_pick_a: assert property (tst |=>
        fr_addr == $past(fa)) else $error("file address");
    skip_zero_a: assert property (fr_rd ##1 fr_rdata == 8'h00
        |=> prefetch_discard) else $error("no discard");
    skip_none_a: assert property (fr_rd ##1 fr_rdata != 8'h00
        |=> !prefetch_discard ##1 instr_ready) else $error("no skip length");
    skip_len_a: assert property (prefetch_discard && !prefetch_two_word
        |=> !instr_ready [*4] ##1 instr_ready) else $error("skip length");
    // a test-skip may be followed by an xor one cycle later
    flags_keep_a: assert property (trd || twr |->
        ##1 $stable(flags) [*8]) else $error("flags changed");
    tst_flags_a: assert property (tst |->
        ##1 $stable(flags) [*4]) else $error("test flags changed");
    cover property (trd);
    cover property (twr);
    cover property (prefetch_discard && prefetch_two_word);
endmodule

// >>> verif/tb_table_access_test_xor_ops.sv
// Purpose: self-checking bench for the decode and execute unit
// Assumes: flash model on the program port, bench drives file data
// Notes: op length is checked in quarter-phases until ready returns
`timescale 1ns/100ps
module tb_table_access_test_xor_ops
    import tat_pkg::*;
;
    logic core_clk, rst_n, instr_valid, prefetch_two_word, ptr_load;
    logic latch_load, instr_ready, prefetch_discard, pm_rd, fr_rd;
    tat_instr_t instr;
    tat_flags_t flags;
    logic [1:0] quarter_phase;
    logic [20:0] pm_addr, ptr_load_value, table_pointer;
    logic [15:0] pm_rdata;
    logic [3:0] bank_select_register;
    logic [11:0] fr_addr;
    logic [7:0] fr_rdata, latch_load_value, table_latch, accumulator;
    logic [7:0][7:0] hold_regs;
    logic busy;
    int err_count = 0;
    int tests_run = 0;
    int discard_n = 0;
    tat_decode_exec dut_u (.core_clk, .rst_n, .instr_valid, .instr,
        .instr_ready, .prefetch_two_word, .prefetch_discard, .quarter_phase,
        .pm_rd, .pm_addr, .pm_rdata, .bank_select_register, .fr_rd,
        .fr_addr, .fr_rdata, .ptr_load, .ptr_load_value, .latch_load,
        .latch_load_value, .table_pointer, .table_latch, .hold_regs,
        .accumulator, .flags, .busy);
    tat_flash_model flash_u (.core_clk, .pm_rd, .pm_addr, .quarter_phase,
        .pm_rdata);
    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // discard pulses counted at the falling edge, where they have settled
    always @(negedge core_clk) begin
        if (prefetch_discard === 1'b1) begin
            discard_n++;
        end
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // offer a word, then count quarters until ready returns
    task automatic exec(tat_instr_t w, int cyc);
        int n;
        @(posedge core_clk);
        instr <= w;
        instr_valid <= 1'b1;
        // ready is looked at once settled, never in the edge's own step
        @(negedge core_clk);
        for (n = 0; n < 20 && instr_ready !== 1'b1; n++) @(negedge core_clk);
        @(posedge core_clk);
        instr_valid <= 1'b0;
        @(negedge core_clk);
        chk("busy", 32'h1, 32'(busy));
        n = 1;
        while (instr_ready !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        chk("idle", 32'h0, 32'(busy));
        chk("quarters", 32'(cyc * 4), 32'(n));
    endtask
    // software loads of pointer and latch
    task automatic preset(logic [20:0] p, logic [7:0] l);
        @(posedge core_clk);
        ptr_load <= 1'b1;
        ptr_load_value <= p;
        latch_load <= 1'b1;
        latch_load_value <= l;
        @(posedge core_clk);
        ptr_load <= 1'b0;
        latch_load <= 1'b0;
    endtask
    // all four pointer modes from start addresses 0x01A357 upward, odd and even
    task automatic t_table(logic wr);
        logic [20:0] p, a, z;
        tat_flags_t f;
        for (int m = 0; m < 4; m++) begin
            p = 21'h01A357 + 21'(m);
            a = p + 21'(m == 3);
            z = a + 21'(m == 1) - 21'(m == 2);
            preset(p, 8'h50 + 8'(m));
            f = flags;
            exec({TAT_TBL_OPC, wr ? TAT_TWR_SEL : TAT_TRD_SEL, 2'(m)}, 2);
            chk("pointer", 32'(z), 32'(table_pointer));
            chk("flags", 32'(f), 32'(flags));
            if (wr) begin
                chk("holding", 32'(8'h50 + 8'(m)), 32'(hold_regs[a[2:0]]));
            end else begin
                chk("latch", 32'(flash_u.fbyte(a)), 32'(table_latch));
            end
        end
    endtask
    // test-skip with chosen file data, access bit and follower size
    task automatic t_skip(logic a, logic [7:0] f, logic [7:0] d,
        logic tw, logic [11:0] fa, int cyc);
        tat_flags_t fl;
        int dn;
        fl = flags;
        dn = discard_n;
        @(posedge core_clk);
        fr_rdata <= d;
        prefetch_two_word <= tw;
        bank_select_register <= 4'h6;
        exec({TAT_TST_OPC, a, f}, cyc);
        chk("discard", 32'(d == 8'h00), 32'(discard_n - dn));
        chk("file address", 32'(fa), 32'(fr_addr));
        chk("flags", 32'(fl), 32'(flags));
    endtask
    // accumulator chain giving negative, zero and plain results
    task automatic t_xor;
        logic [7:0] e, k;
        e = 8'h00;
        for (int i = 0; i < 3; i++) begin
            k = (i == 2) ? 8'h1A : 8'hB5;
            e = e ^ k;
            exec({TAT_XOR_OPC, k}, 1);
            chk("accumulator", 32'(e), 32'(accumulator));
            chk("flags", 32'({e[7], e == 8'h00}), 32'(flags));
        end
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        prefetch_two_word = 1'b0;
        bank_select_register = 4'h0;
        fr_rdata = 8'h00;
        ptr_load = 1'b0;
        ptr_load_value = '0;
        latch_load = 1'b0;
        latch_load_value = 8'h00;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        t_xor;
        t_table(1'b0);
        t_table(1'b1);
        chk("holding idle", 32'hFF, 32'(hold_regs[2]));
        preset(21'h1FFFFF, 8'h00);
        exec({TAT_TBL_OPC, TAT_TRD_SEL, 2'h1}, 2);
        chk("pointer wrap", 32'h0, 32'(table_pointer));
        t_skip(1'b0, 8'h20, 8'h00, 1'b0, 12'h020, 2);
        t_skip(1'b0, 8'h90, 8'h05, 1'b0, 12'hF90, 1);
        t_skip(1'b1, 8'h10, 8'h00, 1'b1, 12'h610, 3);
        give_verdict;
    end
    // a few hundred cycles expected; cut a hang short
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        give_verdict;
    end
endmodule
bind tat_decode_exec tat_decode_exec_sva #(.PTR_W(PTR_W), .HOLD_N(HOLD_N))
    sva_u (.core_clk, .rst_n, .instr_valid, .instr, .instr_ready,
    .quarter_phase,
    .prefetch_two_word, .prefetch_discard, .pm_rd, .pm_addr, .pm_rdata,
    .bank_select_register, .fr_rd, .fr_addr, .fr_rdata, .table_pointer,
    .table_latch, .hold_regs, .accumulator, .flags);
